// file: bench/crc_calc_props.sv
// Port assertions for the checksum unit
`timescale 1ns/10ps
module crc_calc_props
  import crc_calc_pkg::*;
(
  input logic        clk,
  input logic        nrst,
  input logic [1:0]  mode,
  input logic        sum_cmpl,
  input logic        sum_byte_rev,
  input logic        sum_bit_rev,
  input logic        seed_wr,
  input logic [31:0] seed_data,
  input logic        in_valid,
  input logic [1:0]  in_size,
  input logic        in_ready,
  input logic [31:0] result,
  input logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;  // Write taken at this edge
  logic plain; // No result transform active
  assign take = in_valid && in_ready;
  assign plain = !(sum_cmpl || sum_byte_rev || sum_bit_rev);
  // Lone writes on an idle unit finish in one cycle per byte
  chk_byte_time: assert property (
    (take && !busy && in_size == SIZE_BYTE) ##1 !take |-> busy ##1 !busy)
    else $error("byte write not absorbed in one cycle");
  chk_half_time: assert property (
    (take && !busy && in_size == SIZE_HALF) ##1 !take [*2] |-> busy ##1 !busy)
    else $error("half-word write not absorbed in two cycles");
  chk_word_time: assert property (
    (take && !busy && in_size == SIZE_WORD) ##1 !take [*4] |-> busy ##1 !busy)
    else $error("word write not absorbed in four cycles");
  chk_word_busy: assert property (
    take && !busy && in_size == SIZE_WORD |=> busy [*4])
    else $error("busy dropped before word absorbed");
  // Seed shows at once, masked to the mode width
  chk_seed_load: assert property (
    seed_wr && plain |=> result == ($past(seed_data) &
      (mode == MODE_CRC32 ? 32'hffffffff : 32'h0000ffff)))
    else $error("seed not loaded into result");
  chk_upper_zero: assert property (
    mode != MODE_CRC32 && $stable(mode) |=> result[31:16] == 16'h0)
    else $error("upper result half not zero in 16-bit mode");
  chk_busy_cause: assert property (
    $rose(busy) |-> $past(take))
    else $error("busy rose without a write");
  chk_stall_busy: assert property (
    $fell(in_ready) |-> busy)
    else $error("ready dropped while idle");
  cp_stall: cover property ($fell(in_ready));
  cp_word: cover property (take && in_size == SIZE_WORD);
  cp_seed32: cover property (seed_wr && mode == MODE_CRC32);
endmodule : crc_calc_props

bind crc16_crc32_calc_unit crc_calc_props crc_calc_props_inst (.clk, .nrst, .mode, .sum_cmpl,
  .sum_byte_rev, .sum_bit_rev, .seed_wr, .seed_data, .in_valid, .in_size, .in_ready, .result,
  .busy);

// file: bench/dma_feeder.sv
// Bus master model that feeds data writes
`timescale 1ns/10ps
module dma_feeder (
  input  logic        clk,
  input  logic        in_ready,
  output logic        in_valid,
  output logic [31:0] in_data,
  output logic [1:0]  in_size
);
  initial begin
    in_valid = 1'b0;
    in_data = 32'h0;
    in_size = 2'h0;
  end
  // Released data turns over so a stale word never looks valid
  task automatic drop;
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask : drop
  task automatic idle;
    @(negedge clk);
    drop();
  endtask : idle
  // Offer one write; valid stays up for back-to-back bursts
  task automatic send(input logic [31:0] d, input logic [1:0] s, input int gap, output bit ok);
    @(negedge clk);
    if (gap > 0) begin
      drop();
      repeat (gap) @(negedge clk);
    end
    in_valid = 1'b1;
    in_data = d;
    in_size = s;
    for (int n = 0; n < 50 && !in_ready; n++) @(negedge clk);
    ok = in_ready;
    @(posedge clk);
  endtask : send
endmodule : dma_feeder

// file: bench/testbench.sv
// Self-checking bench for the checksum unit
`timescale 1ns/10ps
module testbench;
  import crc_calc_pkg::*;
  // Settings, seed and write of one case
  typedef struct {
    logic [1:0]  m;
    logic [2:0]  df;
    logic [2:0]  sf;
    logic [1:0]  sz;
    logic [31:0] seed;
    logic [31:0] d;
  } row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        data_cmpl = 1'b0, data_byte_rev = 1'b0, data_bit_rev = 1'b0;
  logic        sum_cmpl = 1'b0, sum_byte_rev = 1'b0, sum_bit_rev = 1'b0;
  logic        seed_wr = 1'b0;
  logic [31:0] seed_data = 32'h0;
  logic        in_valid, in_ready, busy;
  logic [31:0] in_data, result;
  logic [1:0]  in_size;
  logic [31:0] crc;  // Reference remainder
  int          failures = 0, comparisons = 0;
  row_t        rows[10] = '{
    '{2'h0, 3'h0, 3'h0, 2'h0, 32'hffff, 32'ha5},
    '{2'h0, 3'h0, 3'h0, 2'h2, 32'h0, 32'h12345678},
    '{2'h1, 3'h0, 3'h0, 2'h1, 32'hffff, 32'habcd},
    '{2'h1, 3'h4, 3'h0, 2'h2, 32'h1d0f, 32'h31323334},
    '{2'h2, 3'h2, 3'h0, 2'h2, 32'hffffffff, 32'hdeadbeef},
    '{2'h2, 3'h1, 3'h0, 2'h1, 32'h0, 32'hc0015a3c},
    '{2'h2, 3'h0, 3'h4, 2'h0, 32'h5a5a5a5a, 32'hffffff81},
    '{2'h0, 3'h0, 3'h2, 2'h1, 32'h1234, 32'h55aa},
    '{2'h2, 3'h0, 3'h1, 2'h2, 32'hffffffff, 32'h0f1e2d3c},
    '{2'h1, 3'h7, 3'h7, 2'h3, 32'hffff, 32'hffff00c3}};

  always #5 clk = ~clk;

  crc16_crc32_calc_unit crc16_crc32_calc_unit_inst (.clk, .nrst, .mode, .data_cmpl,
    .data_byte_rev, .data_bit_rev, .sum_cmpl, .sum_byte_rev, .sum_bit_rev, .seed_wr,
    .seed_data, .in_valid, .in_data, .in_size, .in_ready, .result, .busy);
  dma_feeder dma_feeder_inst (.clk, .in_ready, .in_valid, .in_data, .in_size);

  // One byte into the reference, MSB first
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] b);
    int w;
    logic [31:0] p;
    w = mode == MODE_CRC32 ? 32 : 16;
    p = mode == MODE_CRC32 ? POLY_CRC32 : mode == MODE_CCITT ? POLY_CCITT : POLY_CRC16;
    c = c ^ ({24'h0, b} << (w - 8));
    for (int i = 0; i < 8; i++) c = c[w - 1] ? (c << 1) ^ p : c << 1;
    return w == 32 ? c : c & 32'hffff;
  endfunction : crc_step
  // Result transforms: bit reverse, byte swap, complement
  function automatic logic [31:0] out_of(logic [31:0] c);
    int sh;
    sh = mode == MODE_CRC32 ? 0 : 16;
    if (sum_bit_rev) begin
      c = {<<{c}};
      c = c >> sh;
    end
    if (sum_byte_rev) begin
      c = {<<8{c}};
      c = c >> sh;
    end
    if (sum_cmpl) c = ~c & (32'hffffffff >> sh);
    return c;
  endfunction : out_of
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // Settings plus a one-cycle seed pulse
  task automatic load(input logic [1:0] m, input logic [2:0] df, sf, input logic [31:0] s);
    @(negedge clk);
    mode = m;
    {data_cmpl, data_byte_rev, data_bit_rev} = df;
    {sum_cmpl, sum_byte_rev, sum_bit_rev} = sf;
    seed_wr = 1'b1;
    seed_data = s;
    @(negedge clk);
    seed_wr = 1'b0;
    crc = m == MODE_CRC32 ? s : s & 32'hffff;
  endtask : load
  // Send a write and fold its bytes into the reference
  task automatic feed(input logic [31:0] d, input logic [1:0] s, input int gap);
    bit ok;
    int n;
    logic [7:0] b;
    n = s == SIZE_WORD ? 4 : s == SIZE_HALF ? 2 : 1;
    dma_feeder_inst.send(d, s, gap, ok);
    check("write taken", ok, 32'h1);
    if (!ok) end_sim();
    if (data_cmpl) d = ~d;
    for (int k = 0; k < n; k++) begin
      b = d[8 * (data_byte_rev ? n - 1 - k : k) +: 8];
      if (data_bit_rev) b = {<<{b}};
      crc = crc_step(crc, b);
    end
  endtask : feed
  // Bounded wait for idle, then compare the checksum
  task automatic settle;
    int n;
    dma_feeder_inst.idle();
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk);
    check("busy", busy, 32'h0);
    check("result", result, out_of(crc));
    if (busy !== 1'b0) end_sim();
  endtask : settle

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    check("result", result, 32'h0);
    repeat (2) @(negedge clk);
    check("in_ready", in_ready, 32'h0);
    @(negedge clk);
    check("in_ready", in_ready, 32'h1);
    foreach (rows[i]) begin
      load(rows[i].m, rows[i].df, rows[i].sf, rows[i].seed);
      feed(rows[i].d, rows[i].sz, 0);
      settle();
    end
    // Word burst fills the buffer, slow half-words drain it
    load(MODE_CRC32, 3'h0, 3'h0, 32'hffffffff);
    for (int k = 0; k < 8; k++) begin
      feed(32'h01020304 * k, k < 6 ? SIZE_WORD : SIZE_HALF, k < 6 ? 0 : 3);
    end
    settle();
    // Seed on the second absorbing edge; the last two bytes fold into it
    feed(32'h44332211, SIZE_WORD, 0);
    dma_feeder_inst.idle();
    load(MODE_CRC32, 3'h0, 3'h0, 32'h89abcdef);
    crc = crc_step(crc_step(crc, 8'h33), 8'h44);
    settle();
    // Reset with the word still buffered clears at once; ready returns on the third edge
    feed(32'hcafe0001, SIZE_WORD, 0);
    dma_feeder_inst.idle();
    nrst = 1'b0;
    #1;
    check("busy", busy, 32'h0);
    check("in_ready", in_ready, 32'h0);
    check("result", result, SEED_RESET);
    @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    check("in_ready", in_ready, 32'h0);
    @(negedge clk);
    check("in_ready", in_ready, 32'h1);
    crc = SEED_RESET;
    feed(32'h000000a5, SIZE_BYTE, 0);
    settle();
    end_sim();
  end
endmodule : testbench

// file: pkg/crc_calc_pkg.sv
// Shared constants and types for the checksum calculation unit
package crc_calc_pkg;

  // Generator polynomials
  localparam logic [31:0] POLY_CRC16  = 32'h0000_8005;
  localparam logic [31:0] POLY_CCITT  = 32'h0000_1021;
  localparam logic [31:0] POLY_CRC32  = 32'h04c1_1db7;

  // Reset value of the running checksum
  localparam logic [31:0] SEED_RESET  = 32'h0000_0000;

  // Polynomial select encodings
  typedef enum logic [1:0] {
    MODE_CRC16 = 2'b00,
    MODE_CCITT = 2'b01,
    MODE_CRC32 = 2'b10
  } crc_mode_t;

  // Access size encodings, as on the system bus size field
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } data_size_t;

  // Engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } eng_state_t;

  // Bytes per access size
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_HALF = 3'h2;
  localparam logic [2:0] BYTES_WORD = 3'h4;

  // Buffer depth
  localparam int BUF_DEPTH = 2;

endpackage : crc_calc_pkg

// file: verilog/crc16_crc32_calc_unit.sv
// Checksum calculation unit: byte-serial CRC16/CCITT/CRC32 engine
// Functional notes
// - CRC16 mode uses polynomial 0x8005
// - CCITT mode uses polynomial 0x1021
// - CRC32 mode uses polynomial 0x04C11DB7
// - Optional complement, byte, bit reverse both ways
// - Absorb only bytes of the written size
// - Programmable seed starts subsequent calculation
// - Byte in one cycle, word in four
// - Accept back-to-back data writes from DMA
// - Result is 16 or 32 bits wide
`timescale 1ns/10ps

module crc16_crc32_calc_unit
  import crc_calc_pkg::*;
(
  input  wire logic        clk,            // System clock, 100 MHz
  input  wire logic        nrst,           // Asynchronous reset, active low
  input  wire logic [1:0]  mode,           // Polynomial select
  input  wire logic        data_cmpl,      // Complement incoming data
  input  wire logic        data_byte_rev,  // Reverse byte order of incoming data
  input  wire logic        data_bit_rev,   // Reverse bits within each data byte
  input  wire logic        sum_cmpl,       // Complement the result
  input  wire logic        sum_byte_rev,   // Reverse byte order of the result
  input  wire logic        sum_bit_rev,    // Reverse bit order of the result
  input  wire logic        seed_wr,        // Seed load strobe
  input  wire logic [31:0] seed_data,      // Seed value
  input  wire logic        in_valid,       // Data write offered
  input  wire logic [31:0] in_data,        // Data word, lowest lane first
  input  wire logic [1:0]  in_size,        // Access size of the write
  output logic             in_ready,       // Buffer can take a write
  output logic [31:0]      result,         // Checksum after output transforms
  output logic             busy            // Engine or buffer holds work
);

  // Reset synchroniser
  logic rst_meta;            // First stage, read only by second stage
  logic rst_sync_n;          // Released reset used everywhere
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Reverse bits inside each byte of a word
  function automatic logic [31:0] bit_rev_bytes(input logic [31:0] w);
    logic [31:0] r;
    r = '0;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 8; i++) begin
        r[b*8+i] = w[b*8+7-i];
      end
    end
    return r;
  endfunction : bit_rev_bytes

  // Reverse bits of a whole word
  function automatic logic [31:0] bit_rev_word(input logic [31:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = w[31-i];
    end
    return r;
  endfunction : bit_rev_word

  // Swap byte order over the given number of bytes
  function automatic logic [31:0] byte_swap(input logic [31:0] w, input logic [2:0] n);
    logic [31:0] r;
    r = w;
    if (n == BYTES_HALF) begin
      r = {16'h0000, w[7:0], w[15:8]};
    end else if (n == BYTES_WORD) begin
      r = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
    return r;
  endfunction : byte_swap

  // Bytes carried by an access size
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    logic [2:0] n;
    n = BYTES_BYTE;
    if (s == SIZE_HALF) begin
      n = BYTES_HALF;
    end else if (s == SIZE_WORD) begin
      n = BYTES_WORD;
    end
    return n;
  endfunction : size_bytes

  // One byte step of the MSB-first CRC shift register
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                            input logic [1:0] m);
    logic [31:0] r;
    logic        fb;
    r = c;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (m == MODE_CRC32) begin
        fb = r[31] ^ d[i];
        r  = {r[30:0], 1'b0} ^ (fb ? POLY_CRC32 : 32'h0000_0000);
      end else begin
        fb = r[15] ^ d[i];
        r  = {16'h0000, r[14:0], 1'b0} ^ (fb ? (m == MODE_CCITT ? POLY_CCITT
                                                 : POLY_CRC16)
                                             : 32'h0000_0000);
      end
    end
    return r;
  endfunction : crc_byte

  // Two-entry input buffer; stalls the writer when full
  logic [31:0] buf_data [BUF_DEPTH];   // Stored data words
  logic [2:0]  buf_len  [BUF_DEPTH];   // Stored byte counts
  logic [1:0]  buf_cnt;                // Occupied entries
  logic        buf_wptr;               // Write index
  logic        buf_rptr;               // Read index
  logic [1:0]  next_buf_cnt;
  logic        next_buf_wptr;
  logic        next_buf_rptr;
  logic        buf_push;               // Write accepted this cycle
  logic        buf_pop;                // Engine takes head entry
  logic        next_in_ready;
  logic [31:0] in_xform;               // Input after data transforms

  // Engine state
  eng_state_t  state;
  eng_state_t  next_state;
  logic [31:0] shreg;                  // Data bytes still to absorb
  logic [31:0] next_shreg;
  logic [2:0]  left;                   // Bytes still to absorb
  logic [2:0]  next_left;
  logic [31:0] crc;                    // Running remainder
  logic [31:0] next_crc;
  logic [31:0] next_result;
  logic        next_busy;

  // Input data transforms applied once at the buffer entry
  always_comb begin
    in_xform = in_data;
    if (data_cmpl) begin
      in_xform = ~in_xform;
    end
    if (data_bit_rev) begin
      in_xform = bit_rev_bytes(in_xform);
    end
    if (data_byte_rev) begin
      in_xform = byte_swap(in_xform, size_bytes(in_size));
    end
  end

  // Buffer pointer and count next values
  always_comb begin
    buf_push      = in_valid && in_ready;
    buf_pop       = (buf_cnt != 2'h0) && (state == ST_IDLE || left == BYTES_BYTE);
    next_buf_wptr = buf_push ? ~buf_wptr : buf_wptr;
    next_buf_rptr = buf_pop ? ~buf_rptr : buf_rptr;
    next_buf_cnt  = buf_cnt;
    if (buf_push && !buf_pop) begin
      next_buf_cnt = buf_cnt + 2'h1;
    end else if (!buf_push && buf_pop) begin
      next_buf_cnt = buf_cnt - 2'h1;
    end
    // Ready registered, so it may only claim room that is certain
    next_in_ready = (next_buf_cnt < 2'(BUF_DEPTH));
  end

  // Buffer storage and pointers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      buf_cnt  <= 2'h0;
      buf_wptr <= 1'b0;
      buf_rptr <= 1'b0;
      in_ready <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_data[i] <= 32'h0000_0000;
        buf_len[i]  <= 3'h0;
      end
    end else begin
      buf_cnt  <= next_buf_cnt;
      buf_wptr <= next_buf_wptr;
      buf_rptr <= next_buf_rptr;
      in_ready <= next_in_ready;
      if (buf_push) begin
        buf_data[buf_wptr] <= in_xform;
        buf_len[buf_wptr]  <= size_bytes(in_size);
      end
    end
  end

  // Engine: one byte per cycle from the lowest lane upward
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_left  = left;
    next_crc   = crc;
    case (state)
      ST_IDLE: begin
        if (buf_pop) begin
          // First byte absorbed in the cycle the entry is taken
          next_crc   = crc_byte(crc, buf_data[buf_rptr][7:0], mode);
          next_shreg = {8'h00, buf_data[buf_rptr][31:8]};
          next_left  = buf_len[buf_rptr] - 3'h1;
          next_state = (next_left == 3'h0) ? ST_IDLE : ST_BUSY;
        end
      end
      ST_BUSY: begin
        next_crc  = crc_byte(crc, shreg[7:0], mode);
        if (left == BYTES_BYTE && buf_pop) begin
          // Last byte done; chain into the next entry without a gap
          next_shreg = buf_data[buf_rptr];
          next_left  = buf_len[buf_rptr];
        end else begin
          next_shreg = {8'h00, shreg[31:8]};
          next_left  = left - 3'h1;
          next_state = (left == BYTES_BYTE) ? ST_IDLE : ST_BUSY;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Seed write overrides this cycle's byte step; bytes still in flight fold into the seed
    if (seed_wr) begin
      next_crc = seed_data;
    end
    if (mode != MODE_CRC32) begin
      next_crc = {16'h0000, next_crc[15:0]};
    end
  end

  // Output transforms; pure view of the remainder
  always_comb begin
    next_result = next_crc;
    if (sum_bit_rev) begin
      next_result = bit_rev_word(next_result);
      if (mode != MODE_CRC32) begin
        next_result = {16'h0000, next_result[31:16]};
      end
    end
    if (sum_byte_rev) begin
      next_result = byte_swap(next_result, (mode == MODE_CRC32) ? BYTES_WORD
                                                                : BYTES_HALF);
    end
    if (sum_cmpl) begin
      next_result = ~next_result;
    end
    if (mode != MODE_CRC32) begin
      next_result = {16'h0000, next_result[15:0]};
    end
    next_busy = (next_state == ST_BUSY) || (next_buf_cnt != 2'h0);
  end

  // Engine registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state  <= ST_IDLE;
      shreg  <= 32'h0000_0000;
      left   <= 3'h0;
      crc    <= SEED_RESET;
      result <= SEED_RESET;
      busy   <= 1'b0;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      left   <= next_left;
      crc    <= next_crc;
      result <= next_result;
      busy   <= next_busy;
    end
  end

endmodule : crc16_crc32_calc_unit
